/* feq_pkg.sv */
// constants and types for the channel-b equalization filter upper-tap block
// Functional notes
// - each upper-tap coefficient is signed two's complement in bits 11:0, filter treats it signed.
// - seventh-tap register drives channel-b filter tap seven in dual-channel mode.
// - register index 0x457 supplies tap eight, resets to zero.
// - register index 0x459 supplies tap nine, resets to zero.
// - software readback forces coefficient msb to zero; filter keeps true stored value.
// - bits 15:12 are reserved read/write storage, reset zero, no filter effect.
// - nine taps; centre tap 18-bit, outer taps 12-bit.
package feq_pkg;

	localparam int          REG_W        = 16;
	localparam int          COEFF_W      = 12;
	localparam int          CENTER_W     = 18;
	localparam int          NUM_TAPS     = 9;
	localparam int          NUM_REGS     = 3;
	localparam int          COEFF_MSB    = 11;
	localparam int          RSV_LSB      = 12;
	localparam int          RSV_MSB      = 15;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_TAP7     = 12'h455;
	localparam logic [11:0] IDX_TAP8     = 12'h457;
	localparam logic [11:0] IDX_TAP9     = 12'h459;
	localparam logic [15:0] RESET_COEFF  = 16'h0000;

	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// slot numbers in the register array
	localparam logic [1:0]  SLOT_TAP7    = 2'h0;
	localparam logic [1:0]  SLOT_TAP8    = 2'h1;
	localparam logic [1:0]  SLOT_TAP9    = 2'h2;
	localparam logic [1:0]  SLOT_NONE    = 2'h3;

	typedef struct packed {
		logic signed [COEFF_W-1:0] tap7;
		logic signed [COEFF_W-1:0] tap8;
		logic signed [COEFF_W-1:0] tap9;
	} feq_upper_taps_t;

	// coefficients of taps one to six, kept by other register blocks
	typedef struct packed {
		logic signed [COEFF_W-1:0]  tap1;
		logic signed [COEFF_W-1:0]  tap2;
		logic signed [COEFF_W-1:0]  tap3;
		logic signed [COEFF_W-1:0]  tap4;
		logic signed [CENTER_W-1:0] tap5;
		logic signed [COEFF_W-1:0]  tap6;
	} feq_lower_taps_t;

endpackage

/* feq_upper_taps.sv */
// channel-b equalization filter: upper-tap coefficient registers and 9-tap filter
//
// Our own choice: the AXI4-Lite interface to the registers.
module feq_upper_taps #(
	parameter int ADDR_W   = 16,
	parameter int SAMPLE_W = 12
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          dual_channel_mode,
	input  wire feq_pkg::feq_lower_taps_t      lower_taps,
	input  wire logic signed [SAMPLE_W-1:0]    sample_in,
	input  wire logic                          sample_valid,
	output feq_pkg::feq_upper_taps_t           upper_taps,
	output logic signed [SAMPLE_W+feq_pkg::CENTER_W+3:0] filter_out,
	output logic                               filter_valid
);

	localparam int PROD_W = SAMPLE_W + feq_pkg::CENTER_W;
	localparam int SUM_W  = PROD_W + 4;

	initial begin
		if (ADDR_W < 14 || ADDR_W > 32) begin
			$error("ADDR_W must lie between 14 and 32");
		end
		if (SAMPLE_W < 2 || SAMPLE_W > 16) begin
			$error("SAMPLE_W must lie between 2 and 16");
		end
		if (feq_pkg::NUM_REGS != 3 || feq_pkg::NUM_TAPS != 9) begin
			$error("register and tap counts are fixed by the slot map");
		end
		if (feq_pkg::COEFF_MSB != feq_pkg::COEFF_W - 1) begin
			$error("coefficient msb must be the top bit of the field");
		end
		if (feq_pkg::RSV_MSB != feq_pkg::REG_W - 1 || feq_pkg::RSV_LSB != feq_pkg::COEFF_W) begin
			$error("reserved nibble must sit directly above the coefficient");
		end
		if (feq_pkg::CENTER_W < feq_pkg::COEFF_W) begin
			$error("centre tap must be at least as wide as the outer taps");
		end
	end

	// byte address to register slot
	function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] idx;
		idx = addr >> 2;
		if (addr[1:0] != 2'h0) begin
			slot_of = feq_pkg::SLOT_NONE;
		end else if (idx == ADDR_W'(feq_pkg::IDX_TAP7)) begin
			slot_of = feq_pkg::SLOT_TAP7;
		end else if (idx == ADDR_W'(feq_pkg::IDX_TAP8)) begin
			slot_of = feq_pkg::SLOT_TAP8;
		end else if (idx == ADDR_W'(feq_pkg::IDX_TAP9)) begin
			slot_of = feq_pkg::SLOT_TAP9;
		end else begin
			slot_of = feq_pkg::SLOT_NONE;
		end
	endfunction

	logic [feq_pkg::REG_W-1:0] coeff_ff [feq_pkg::NUM_REGS];

	// write channel: address and data held independently, either order
	logic              aw_held_ff;
	logic              w_held_ff;
	logic [1:0]        aw_slot_ff;
	logic [15:0]       w_data_ff;
	logic [1:0]        w_strb_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;

	wire               aw_take = s_axi_awvalid && s_axi_awready;
	wire               w_take  = s_axi_wvalid && s_axi_wready;
	wire               do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	wire               wr_hit   = do_write && (aw_slot_ff != feq_pkg::SLOT_NONE);

	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// address side of the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_slot_ff <= feq_pkg::SLOT_NONE;
		end else if (aw_take) begin
			aw_held_ff <= 1'b1;
			aw_slot_ff <= slot_of(s_axi_awaddr);
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	// data side of the write; upper lanes never reach a register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			w_data_ff <= 16'h0000;
			w_strb_ff <= 2'h0;
		end else if (w_take) begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata[15:0];
			w_strb_ff <= s_axi_wstrb[1:0];
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	// unmapped or misaligned writes are answered but change nothing
	wire [1:0]         wr_resp  = wr_hit ? feq_pkg::RESP_OKAY : feq_pkg::RESP_SLVERR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_ff <= feq_pkg::RESP_OKAY;
		end else if (do_write) begin
			bresp_ff <= wr_resp;
		end
	end

	// full 16 bits stored, reserved nibble included
	genvar g;
	generate
		for (g = 0; g < feq_pkg::NUM_REGS; g++) begin : g_reg
			wire sel   = wr_hit && (aw_slot_ff == 2'(g));
			wire lo_we = sel && w_strb_ff[0];
			wire hi_we = sel && w_strb_ff[1];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					coeff_ff[g] <= feq_pkg::RESET_COEFF;
				end else begin
					if (lo_we) begin
						coeff_ff[g][7:0] <= w_data_ff[7:0];
					end
					if (hi_we) begin
						coeff_ff[g][15:8] <= w_data_ff[15:8];
					end
				end
			end
		end
	endgenerate

	// read channel: one outstanding, answer one cycle after address taken
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;

	wire               ar_take = s_axi_arvalid && s_axi_arready;
	wire [1:0]         ar_slot = slot_of(s_axi_araddr);
	wire [15:0]        ar_word = (ar_slot == feq_pkg::SLOT_NONE) ? 16'h0000 : coeff_ff[ar_slot];
	// sign bit reads back as zero; the stored copy feeding the filter is untouched
	wire [15:0]        ar_view = {ar_word[feq_pkg::RSV_MSB:feq_pkg::RSV_LSB], 1'b0,
	                              ar_word[feq_pkg::COEFF_MSB-1:0]};

	wire               ar_hit  = (ar_slot != feq_pkg::SLOT_NONE);
	wire [1:0]         ar_resp = ar_hit ? feq_pkg::RESP_OKAY : feq_pkg::RESP_SLVERR;

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// data and response are captured once and stand until the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_ff <= 32'h00000000;
			rresp_ff <= feq_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rdata_ff <= {16'h0000, ar_view};
			rresp_ff <= ar_resp;
		end
	end

	// coefficient view for the datapath: low 12 bits, signed
	assign upper_taps.tap7 = signed'(coeff_ff[feq_pkg::SLOT_TAP7][feq_pkg::COEFF_MSB:0]);
	assign upper_taps.tap8 = signed'(coeff_ff[feq_pkg::SLOT_TAP8][feq_pkg::COEFF_MSB:0]);
	assign upper_taps.tap9 = signed'(coeff_ff[feq_pkg::SLOT_TAP9][feq_pkg::COEFF_MSB:0]);

	// full coefficient set at the centre tap width, outer taps widened to it
	logic signed [feq_pkg::CENTER_W-1:0] tap_c [feq_pkg::NUM_TAPS];
	assign tap_c[0] = feq_pkg::CENTER_W'(lower_taps.tap1);
	assign tap_c[1] = feq_pkg::CENTER_W'(lower_taps.tap2);
	assign tap_c[2] = feq_pkg::CENTER_W'(lower_taps.tap3);
	assign tap_c[3] = feq_pkg::CENTER_W'(lower_taps.tap4);
	assign tap_c[4] = lower_taps.tap5;
	assign tap_c[5] = feq_pkg::CENTER_W'(lower_taps.tap6);
	assign tap_c[6] = feq_pkg::CENTER_W'(upper_taps.tap7);
	assign tap_c[7] = feq_pkg::CENTER_W'(upper_taps.tap8);
	assign tap_c[8] = feq_pkg::CENTER_W'(upper_taps.tap9);

	// delay line: slot 0 newest, slot 8 oldest
	logic signed [SAMPLE_W-1:0] dly_ff [feq_pkg::NUM_TAPS];
	logic signed [PROD_W-1:0]   prod   [feq_pkg::NUM_TAPS];
	wire                        run = sample_valid && dual_channel_mode;

	generate
		for (g = 0; g < feq_pkg::NUM_TAPS; g++) begin : g_tap
			if (g == 0) begin : g_head
				always_ff @(posedge aclk) begin
					if (!aresetn) begin
						dly_ff[g] <= '0;
					end else if (run) begin
						dly_ff[g] <= sample_in;
					end
				end
			end else begin : g_body
				always_ff @(posedge aclk) begin
					if (!aresetn) begin
						dly_ff[g] <= '0;
					end else if (run) begin
						dly_ff[g] <= dly_ff[g-1];
					end
				end
			end
			// operands widened first, else the product is cut to the wider operand
			wire signed [PROD_W-1:0] smp_x = PROD_W'(dly_ff[g]);
			wire signed [PROD_W-1:0] cof_x = PROD_W'(tap_c[g]);
			assign prod[g] = smp_x * cof_x;
		end
	endgenerate

	logic signed [SUM_W-1:0] sum;
	always_comb begin
		sum = '0;
		for (int i = 0; i < feq_pkg::NUM_TAPS; i++) begin
			sum = sum + SUM_W'(prod[i]);
		end
	end

	// one cycle after a sample shifts in, the sum is registered out
	logic run_d_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_d_ff <= 1'b0;
		end else begin
			run_d_ff <= run;
		end
	end

	// a mode drop between shift and result suppresses the strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filter_valid <= 1'b0;
		end else begin
			filter_valid <= run_d_ff && dual_channel_mode;
		end
	end

	// result holds until the next sample has shifted through
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filter_out <= '0;
		end else if (run_d_ff) begin
			filter_out <= sum;
		end
	end

endmodule

/* feq_upper_taps_sva.sv */
// checker for bus, coefficient and filter timing of the upper-tap block
module feq_upper_taps_chk (
	input logic                     aclk,
	input logic                     aresetn,
	input logic [1:0]               s_axi_bresp,
	input logic                     s_axi_bvalid,
	input logic                     s_axi_bready,
	input logic                     s_axi_arvalid,
	input logic                     s_axi_arready,
	input logic [31:0]              s_axi_rdata,
	input logic                     s_axi_rvalid,
	input logic                     s_axi_rready,
	input logic                     dual_channel_mode,
	input logic                     sample_valid,
	input feq_pkg::feq_upper_taps_t upper_taps,
	input logic                     filter_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_rd_msb_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[11])
		else $error("readback msb set");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data moved");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_tap_cause: assert property ($changed(upper_taps) |-> $rose(s_axi_bvalid))
		else $error("taps moved without write");
	a_tap_reset: assert property ($rose(aresetn) |-> upper_taps == '0)
		else $error("taps not zero after reset");
	a_fv_timing: assert property (sample_valid && dual_channel_mode ##1 dual_channel_mode
		|=> filter_valid) else $error("filter result missing");
	a_fv_cause: assert property (filter_valid |-> $past(sample_valid, 2) &&
		$past(dual_channel_mode, 2)) else $error("filter result without sample");
endmodule

bind feq_upper_taps feq_upper_taps_chk u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.dual_channel_mode, .sample_valid, .upper_taps, .filter_valid);

/* tb.sv */
// bench for the upper-tap block: register access and impulse through the filter
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, dual_channel_mode = 0, sample_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, filter_valid;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic signed [11:0] sample_in = 0;
	logic signed [33:0] filter_out;
	feq_pkg::feq_lower_taps_t lower_taps = {12'h001, 12'h002, 12'h003, 12'h004, 18'h00005, 12'h006};
	feq_pkg::feq_upper_taps_t upper_taps;
	int n_fail = 0, checks_done = 0, nout = 0;
	int e[9] = '{-3, -6, -9, -12, -15, -18, 3, 6144, 4044};
	logic [15:0] a[3] = '{16'h1154, 16'h115C, 16'h1164};
	logic [31:0] w[3] = '{32'h1234FFFF, 32'h0000A800, 32'h00005ABC};
	logic [31:0] r[3] = '{32'h0000F7FF, 32'h0000A000, 32'h000052BC};

	feq_upper_taps dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dual_channel_mode, .lower_taps,
		.sample_in, .sample_valid, .upper_taps, .filter_out, .filter_valid);

	always #2.5 aclk = ~aclk;

	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask

	// response ready from the start; each channel held until it is taken
	task wr(input logic [15:0] ad, input logic [31:0] d, input logic [1:0] rs);
		bit at, dt;
		logic [1:0] got;
		at = 0;
		dt = 0;
		got = 2'h0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(at && dt)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				at = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				dt = 1;
				s_axi_wvalid <= 0;
			end
		end
		do begin
			@(posedge aclk);
			got = s_axi_bresp;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		@(posedge aclk);
		chk(got === rs, "write response");
	endtask

	task rd(input logic [15:0] ad, input logic [31:0] d, input logic [1:0] rs);
		logic [31:0] got;
		logic [1:0] gr;
		got = 32'h00000000;
		gr = 2'h0;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do begin
			@(posedge aclk);
			got = s_axi_rdata;
			gr = s_axi_rresp;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		@(posedge aclk);
		chk(got === d && gr === rs, "read data");
	endtask

	always @(posedge aclk) if (filter_valid === 1'b1) begin
		if (nout < 9) chk(filter_out === 34'(e[nout]), "filter output");
		nout++;
	end

	initial begin
		#10000;
		n_fail++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(upper_taps === '0, "taps after reset");
		for (int i = 0; i < 3; i++) rd(a[i], 32'h0, feq_pkg::RESP_OKAY);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			wr(a[i], w[i], feq_pkg::RESP_OKAY);
			rd(a[i], r[i], feq_pkg::RESP_OKAY);
		end
		chk(upper_taps === {12'hFFF, 12'h800, 12'hABC}, "stored taps");
		wr(16'h1158, 32'hFFFF, feq_pkg::RESP_SLVERR);
		rd(16'h1158, 32'h0, feq_pkg::RESP_SLVERR);
		chk(upper_taps === {12'hFFF, 12'h800, 12'hABC}, "taps after unmapped write");
		$display("test registers done");
		sample_in <= 12'sd5;
		sample_valid <= 1;
		@(posedge aclk);
		sample_valid <= 0;
		repeat (4) @(posedge aclk);
		chk(nout == 0, "output outside dual mode");
		dual_channel_mode <= 1;
		for (int k = 0; k < 9; k++) begin
			sample_in <= (k == 0) ? -12'sd3 : 12'sd0;
			sample_valid <= 1;
			@(posedge aclk);
		end
		sample_valid <= 0;
		repeat (4) @(posedge aclk);
		chk(nout == 9, "filter result count");
		$display("test filter done");
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(upper_taps === '0, "taps after second reset");
		rd(a[2], 32'h0, feq_pkg::RESP_OKAY);
		$display("test second reset done");
		conclude();
	end
endmodule
